// ==== hdl/owd_consts.svh ====
// Summary of operation
// - restart bus watchdog only on accepted exchange
// - bus watchdog expiry forces outputs false
// - application watchdog fires on local silence
// - both watchdogs default to 100 ms
// - tick lasts divider plus two base periods
// - shared tick, separate count per watchdog
// - divider resets to 2498, 100 us tick
// - bus watchdog count resets to 1000
// - count 0..65535, divider 1..65535 accepted
// - bus watchdog count zero disables it
// - power-on enters init, no traffic allowed
// - init to configuration checks mailbox setup
// - configuration state: mailbox yes, process data no
// - check setup, copy inputs before inputs-only
// - inputs-only: traffic allowed, outputs held safe
// - running state drives master outputs to pins
// - boot state entered only from init
// - boot allows file-transfer mailbox only
`ifndef OWD_CONSTS_SVH
`define OWD_CONSTS_SVH

// register offsets on the register port
`define OWD_REG_TICK_DIV 12'h400
`define OWD_REG_APP_WD 12'h410
`define OWD_REG_SYNC_WD 12'h420

// reset values
`define OWD_TICK_DIV_RST 16'h09C2
`define OWD_SYNC_WD_RST 16'h03E8
`define OWD_APP_WD_RST 16'h03E8

// timing: core clock, watchdog base clock, extra base periods per tick
`define OWD_CORE_FREQ_MHZ 40
`define OWD_BASE_FREQ_MHZ 25
`define OWD_CORE_PERIOD_NS (1000 / `OWD_CORE_FREQ_MHZ)
`define OWD_BASE_PERIOD_NS (1000 / `OWD_BASE_FREQ_MHZ)
`define OWD_TICK_EXTRA 2

// state codes on the request and report ports
`define OWD_CODE_INIT 4'h1
`define OWD_CODE_CONFIG 4'h2
`define OWD_CODE_INPUTS 4'h4
`define OWD_CODE_RUN 4'h8
`define OWD_CODE_BOOT 4'h3

`endif

// ==== hdl/owd_pkg.sv ====
package owd_pkg;

  // slave communication states
  typedef enum logic [2:0] {
    s_init,
    s_configuration,
    s_inputs_only,
    s_running,
    s_boot
  } owd_slave_state_t;

endpackage

// ==== hdl/owd_tick_gen.sv ====
`timescale 1ns/100ps
`include "owd_consts.svh"
module owd_tick_gen (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] divider,
  output logic tick
);

  typedef struct packed {
    logic [7:0] acc;
    logic [16:0] cnt;
    logic tick;
  } owd_tick_st_t;

  owd_tick_st_t q;
  owd_tick_st_t d;

  // fractional step turns the core clock into base periods, then count them
  always_comb begin
    d = q;
    d.tick = 1'b0;
    d.acc = q.acc + 8'(`OWD_CORE_PERIOD_NS);
    if (d.acc >= 8'(`OWD_BASE_PERIOD_NS)) begin
      d.acc = d.acc - 8'(`OWD_BASE_PERIOD_NS);
      if (q.cnt >= {1'b0, divider} + 17'(`OWD_TICK_EXTRA - 1)) begin
        d.cnt = 17'h0_0000;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 17'h0_0001;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  // divider is never below one, so ticks are at least three base periods apart
  a_tick_spacing: assert property (
    @(posedge core_clk) disable iff (reset) tick |=> !tick [*3])
    else $error("watchdog ticks too close together");

endmodule

// ==== hdl/owd_top.sv ====
`timescale 1ns/100ps
`include "owd_consts.svh"
module owd_top #(
  parameter int IO_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic state_req_valid,
  input wire logic [3:0] state_req,
  output logic [3:0] state_code,
  output logic state_err,
  input wire logic mbx_cfg_ok,
  input wire logic pd_cfg_ok,
  input wire logic clk_sync_ok,
  input wire logic mbx_req,
  input wire logic mbx_file,
  output logic mbx_ack,
  output logic mbx_nak,
  input wire logic pd_req,
  input wire logic [IO_W-1:0] pd_wdata,
  output logic [IO_W-1:0] pd_rdata,
  output logic pd_ack,
  output logic pd_nak,
  input wire logic app_access,
  input wire logic [IO_W-1:0] in_pins,
  output logic [IO_W-1:0] out_pins,
  output logic sync_wd_expired,
  output logic app_wd_expired
);

  typedef struct packed {
    owd_pkg::owd_slave_state_t st;
    logic [15:0] tick_div;
    logic [15:0] app_time;
    logic [15:0] sync_time;
    logic [15:0] sync_cnt;
    logic [15:0] app_cnt;
    logic sync_exp;
    logic app_exp;
    logic [IO_W-1:0] s1;
    logic [IO_W-1:0] s2;
    logic [IO_W-1:0] s3;
    logic [IO_W-1:0] in_stable;
    logic [IO_W-1:0] in_image;
    logic [IO_W-1:0] out_latch;
    logic [IO_W-1:0] out_pins;
    logic [15:0] rdata;
    logic [3:0] code;
    logic pd_ack;
    logic pd_nak;
    logic mbx_ack;
    logic mbx_nak;
    logic err;
  } owd_core_t;

  owd_core_t q;
  owd_core_t d;
  logic tick;
  logic pd_ok;
  logic pd_accept;
  logic mbx_ok;
  logic [16:0] sync_step;
  logic [16:0] app_step;

  // one watchdog step: returns {expired, count}
  function automatic logic [16:0] owd_wd_step(
    input logic [15:0] limit,
    input logic [15:0] cnt,
    input logic exp,
    input logic restart,
    input logic tk
  );
    logic [16:0] r;
    r = {exp, cnt};
    if (limit == 16'h0000) begin
      r = 17'h0_0000;
    end else if (restart) begin
      r = 17'h0_0000;
    end else if (tk && !exp) begin
      if ({1'b0, cnt} + 17'h0_0001 >= {1'b0, limit}) begin
        r = {1'b1, cnt};
      end else begin
        r = {1'b0, cnt + 16'h0001};
      end
    end
    return r;
  endfunction

  // state report code
  function automatic logic [3:0] owd_code_of(input owd_pkg::owd_slave_state_t s);
    case (s)
      owd_pkg::s_init: owd_code_of = `OWD_CODE_INIT;
      owd_pkg::s_configuration: owd_code_of = `OWD_CODE_CONFIG;
      owd_pkg::s_inputs_only: owd_code_of = `OWD_CODE_INPUTS;
      owd_pkg::s_running: owd_code_of = `OWD_CODE_RUN;
      owd_pkg::s_boot: owd_code_of = `OWD_CODE_BOOT;
      default: owd_code_of = `OWD_CODE_INIT;
    endcase
  endfunction

  owd_tick_gen u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .divider(q.tick_div),
    .tick(tick)
  );

  // traffic gating per state
  always_comb begin
    pd_ok = (q.st == owd_pkg::s_inputs_only) || (q.st == owd_pkg::s_running);
    pd_accept = pd_req && pd_ok;
    mbx_ok = (q.st == owd_pkg::s_configuration) || pd_ok ||
             ((q.st == owd_pkg::s_boot) && mbx_file);
    sync_step = owd_wd_step(q.sync_time, q.sync_cnt, q.sync_exp, pd_accept, tick);
    app_step = owd_wd_step(q.app_time, q.app_cnt, q.app_exp, app_access, tick);
  end

  // next state of the whole block
  always_comb begin
    d = q;
    d.pd_ack = pd_accept;
    d.pd_nak = pd_req && !pd_ok;
    d.mbx_ack = mbx_req && mbx_ok;
    d.mbx_nak = mbx_req && !mbx_ok;

    // pin inputs: three stages, a change counts once stages two and three agree
    d.s1 = in_pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.in_stable = (q.s2 & q.s3) | (q.in_stable & (q.s2 | q.s3));

    // register port writes
    if (reg_wr) begin
      case (reg_addr)
        `OWD_REG_TICK_DIV: begin
          if (reg_wdata != 16'h0000) begin
            d.tick_div = reg_wdata;
          end
        end
        `OWD_REG_APP_WD: d.app_time = reg_wdata;
        `OWD_REG_SYNC_WD: d.sync_time = reg_wdata;
        default: d.err = q.err;
      endcase
    end

    // register port reads, unmapped reads as zero
    if (reg_rd) begin
      case (reg_addr)
        `OWD_REG_TICK_DIV: d.rdata = q.tick_div;
        `OWD_REG_APP_WD: d.rdata = q.app_time;
        `OWD_REG_SYNC_WD: d.rdata = q.sync_time;
        default: d.rdata = 16'h0000;
      endcase
    end

    // watchdog counters
    // zero count keeps the watchdog off
    {d.sync_exp, d.sync_cnt} = sync_step;
    {d.app_exp, d.app_cnt} = app_step;

    // accepted output data is latched
    if (pd_accept) begin
      d.out_latch = pd_wdata;
    end

    if (pd_ok) begin
      d.in_image = q.in_stable;
    end

    if (state_req_valid) begin
      d.err = 1'b1;
      case (state_req)
        `OWD_CODE_INIT: begin
          d.st = owd_pkg::s_init;
          d.err = 1'b0;
        end
        `OWD_CODE_CONFIG: begin
          if ((q.st == owd_pkg::s_init && mbx_cfg_ok) || pd_ok ||
              q.st == owd_pkg::s_configuration) begin
            d.st = owd_pkg::s_configuration;
            d.err = 1'b0;
          end
        end
        `OWD_CODE_INPUTS: begin
          // checks, then inputs copied with the state change
          if (q.st == owd_pkg::s_configuration && pd_cfg_ok && clk_sync_ok) begin
            d.in_image = q.in_stable;
            d.st = owd_pkg::s_inputs_only;
            d.err = 1'b0;
          end else if (pd_ok) begin
            d.st = owd_pkg::s_inputs_only;
            d.err = 1'b0;
          end
        end
        `OWD_CODE_RUN: begin
          if (pd_ok) begin
            d.st = owd_pkg::s_running;
            d.err = 1'b0;
          end
        end
        `OWD_CODE_BOOT: begin
          if (q.st == owd_pkg::s_init || q.st == owd_pkg::s_boot) begin
            d.st = owd_pkg::s_boot;
            d.err = 1'b0;
          end
        end
        default: d.err = 1'b1;
      endcase
    end
    d.code = owd_code_of(d.st);

    if (d.st == owd_pkg::s_running && !d.sync_exp) begin
      d.out_pins = d.out_latch;
    end else begin
      d.out_pins = '0;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
      q.st <= owd_pkg::s_init;
      q.code <= `OWD_CODE_INIT;
      q.tick_div <= `OWD_TICK_DIV_RST;
      q.sync_time <= `OWD_SYNC_WD_RST;
      q.app_time <= `OWD_APP_WD_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign state_code = q.code;
  assign state_err = q.err;
  assign mbx_ack = q.mbx_ack;
  assign mbx_nak = q.mbx_nak;
  assign pd_rdata = q.in_image;
  assign pd_ack = q.pd_ack;
  assign pd_nak = q.pd_nak;
  assign out_pins = q.out_pins;
  assign sync_wd_expired = q.sync_exp;
  assign app_wd_expired = q.app_exp;

  default clocking owd_cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // process data request while traffic is closed
  sequence seq_pd_closed;
    pd_req && !(q.st == owd_pkg::s_inputs_only || q.st == owd_pkg::s_running);
  endsequence

  sequence seq_pd_refused;
    pd_nak && !pd_ack;
  endsequence

  sequence seq_enter_inputs;
    q.st == owd_pkg::s_inputs_only && $past(q.st) == owd_pkg::s_configuration;
  endsequence

  a_pd_restart: assert property (
    pd_accept |=> q.sync_cnt == 16'h0000 && !sync_wd_expired)
    else $error("accepted exchange did not restart watchdog");

  a_expiry_outputs: assert property (
    sync_wd_expired |-> out_pins == '0)
    else $error("outputs not false after watchdog expiry");

  a_app_trigger: assert property (
    tick && q.app_time != 16'h0000 && !q.app_exp && !app_access &&
    {1'b0, q.app_cnt} + 17'h0_0001 >= {1'b0, q.app_time} |=> app_wd_expired)
    else $error("application watchdog did not fire");

  a_reset_values: assert property (
    $fell(reset) |-> q.tick_div == 16'h09C2 && q.sync_time == 16'h03E8 &&
    q.app_time == 16'h03E8 && q.st == owd_pkg::s_init)
    else $error("wrong values after reset");

  a_div_zero: assert property (
    reg_wr && reg_addr == 12'h400 && reg_wdata == 16'h0000 |=>
    q.tick_div == $past(q.tick_div))
    else $error("divider accepted zero");

  a_wd_disabled: assert property (
    q.sync_time == 16'h0000 |=> !sync_wd_expired)
    else $error("disabled watchdog expired");

  a_closed_refuse: assert property (
    seq_pd_closed |=> seq_pd_refused)
    else $error("process data accepted while closed");

  a_config_check: assert property (
    q.st == owd_pkg::s_configuration && $past(q.st) == owd_pkg::s_init |->
    $past(mbx_cfg_ok))
    else $error("configuration entered without mailbox check");

  a_input_copy: assert property (
    seq_enter_inputs |-> q.in_image == $past(q.in_stable) && $past(pd_cfg_ok))
    else $error("inputs not copied on entry");

  a_safe_hold: assert property (
    q.st == owd_pkg::s_inputs_only |-> out_pins == '0)
    else $error("outputs not safe in inputs-only state");

  a_run_drive: assert property (
    q.st == owd_pkg::s_running && !q.sync_exp |-> out_pins == q.out_latch)
    else $error("running outputs differ from master data");

  a_boot_entry: assert property (
    q.st == owd_pkg::s_boot && $past(q.st) != owd_pkg::s_boot |->
    $past(q.st) == owd_pkg::s_init)
    else $error("boot entered from wrong state");

  a_boot_mbx: assert property (
    q.st == owd_pkg::s_boot && mbx_req && !mbx_file |=> mbx_nak)
    else $error("boot accepted non-file mailbox");

endmodule

// ==== tb/owd_master_model.sv ====
`timescale 1ns/100ps
module owd_master_model #(
  parameter int IO_W = 8
) (
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [11:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  output logic state_req_valid,
  output logic [3:0] state_req,
  output logic mbx_req,
  output logic mbx_file,
  output logic pd_req,
  output logic [IO_W-1:0] pd_wdata
);
  // idle levels at time zero
  initial begin
    {reg_wr, reg_rd, state_req_valid, mbx_req, mbx_file, pd_req} = '0;
    {reg_addr, reg_wdata, state_req, pd_wdata} = '0;
  end
  // register access; released lines show the inverse of the last value
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b0, ~a};
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  // master asks for a state change
  task automatic set_state(input logic [3:0] c);
    @(posedge core_clk);
    {state_req_valid, state_req} <= {1'b1, c};
    @(posedge core_clk);
    {state_req_valid, state_req} <= {1'b0, ~c};
  endtask
  // output image sent as one frame
  task automatic send_pd(input logic [IO_W-1:0] d);
    @(posedge core_clk);
    {pd_req, pd_wdata} <= {1'b1, d};
    @(posedge core_clk);
    {pd_req, pd_wdata} <= {1'b0, ~d};
  endtask
  // mailbox exchange, file transfer or not
  task automatic send_mbx(input logic f);
    @(posedge core_clk);
    {mbx_req, mbx_file} <= {1'b1, f};
    @(posedge core_clk);
    {mbx_req, mbx_file} <= {1'b0, ~f};
  endtask
endmodule

// ==== tb/owd_top_tb.sv ====
`timescale 1ns/100ps
module owd_top_tb;
  logic core_clk, reset, mbx_cfg_ok, pd_cfg_ok, clk_sync_ok, app_access;
  logic reg_wr, reg_rd, state_req_valid, mbx_req, mbx_file, pd_req;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0] state_req, state_code;
  logic [7:0] pd_wdata, pd_rdata, in_pins, out_pins;
  logic state_err, mbx_ack, mbx_nak, pd_ack, pd_nak, sync_wd_expired, app_wd_expired;
  int n_mismatch = 0;
  int check_count = 0;

  owd_top #(.IO_W(8)) DUT (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .state_req_valid(state_req_valid), .state_req(state_req), .state_code(state_code),
    .state_err(state_err), .mbx_cfg_ok(mbx_cfg_ok), .pd_cfg_ok(pd_cfg_ok),
    .clk_sync_ok(clk_sync_ok), .mbx_req(mbx_req), .mbx_file(mbx_file), .mbx_ack(mbx_ack),
    .mbx_nak(mbx_nak), .pd_req(pd_req), .pd_wdata(pd_wdata), .pd_rdata(pd_rdata),
    .pd_ack(pd_ack), .pd_nak(pd_nak), .app_access(app_access), .in_pins(in_pins),
    .out_pins(out_pins), .sync_wd_expired(sync_wd_expired), .app_wd_expired(app_wd_expired));

  owd_master_model #(.IO_W(8)) m (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .state_req_valid(state_req_valid), .state_req(state_req), .mbx_req(mbx_req),
    .mbx_file(mbx_file), .pd_req(pd_req), .pd_wdata(pd_wdata));

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // compares one value, counts and reports
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // reset values and unmapped read
  task automatic t_regs;
    logic [15:0] d;
    chk(16'(state_code), 16'h0001);
    m.rd_reg(12'h400, d); chk(d, 16'h09c2);
    m.rd_reg(12'h420, d); chk(d, 16'h03e8);
    m.rd_reg(12'h410, d); chk(d, 16'h03e8);
    m.rd_reg(12'h430, d); chk(d, 16'h0000);
  endtask

  // init refusals and mailbox check on entry to configuration
  task automatic t_init;
    m.send_mbx(1'b0); #1 chk(16'(mbx_nak), 16'h0001);
    m.send_pd(8'h5a); #1 chk(16'(pd_nak), 16'h0001);
    m.set_state(4'h8); #1 chk(16'(state_err), 16'h0001);
    m.set_state(4'h2); #1 chk(16'(state_code), 16'h0001);
    @(posedge core_clk) mbx_cfg_ok <= 1'b1;
    m.set_state(4'h2); #1 chk(16'(state_code), 16'h0002);
    chk(16'(state_err), 16'h0000);
  endtask

  // configuration state, then inputs-only with input snapshot
  task automatic t_config;
    m.send_mbx(1'b0); #1 chk(16'(mbx_ack), 16'h0001);
    m.send_pd(8'h3c); #1 chk(16'(pd_nak), 16'h0001);
    m.set_state(4'h4); #1 chk(16'(state_err), 16'h0001);
    chk(16'(state_code), 16'h0002);
    @(posedge core_clk) {in_pins, pd_cfg_ok, clk_sync_ok} <= {8'ha5, 2'b11};
    repeat (6) @(posedge core_clk);
    m.set_state(4'h4); #1 chk(16'(state_code), 16'h0004);
    chk(16'(pd_rdata), 16'h00a5);
    m.send_pd(8'hff); #1 chk(16'(pd_ack), 16'h0001);
    @(posedge core_clk) #1 chk(16'(out_pins), 16'h0000);
  endtask

  // running state and both watchdogs with a short tick
  task automatic t_run;
    logic [15:0] d;
    m.set_state(4'h8); #1 chk(16'(state_code), 16'h0008);
    m.send_pd(8'h96); #1 chk(16'(out_pins), 16'h0096);
    m.send_mbx(1'b0); #1 chk(16'(mbx_ack), 16'h0001);
    m.wr_reg(12'h400, 16'h0001);
    m.wr_reg(12'h420, 16'h0002);
    m.rd_reg(12'h400, d); chk(d, 16'h0001);
    repeat (5) begin
      m.send_pd(8'h96);
      @(posedge core_clk) #1 chk(16'(sync_wd_expired), 16'h0000);
    end
    repeat (20) @(posedge core_clk);
    #1 chk(16'(sync_wd_expired), 16'h0001);
    chk(16'(out_pins), 16'h0000);
    chk(16'(state_code), 16'h0008);
    m.send_pd(8'h81);
    @(posedge core_clk) #1 chk(16'(sync_wd_expired), 16'h0000);
    m.wr_reg(12'h420, 16'h0000);
    repeat (30) @(posedge core_clk);
    #1 chk(16'(sync_wd_expired), 16'h0000);
    m.wr_reg(12'h410, 16'h0002);
    repeat (20) @(posedge core_clk);
    #1 chk(16'(app_wd_expired), 16'h0001);
    @(posedge core_clk) app_access <= 1'b1;
    @(posedge core_clk) app_access <= 1'b0;
    @(posedge core_clk) #1 chk(16'(app_wd_expired), 16'h0000);
    @(posedge core_clk) in_pins <= 8'h3c;
    repeat (6) @(posedge core_clk);
    #1 chk(16'(pd_rdata), 16'h003c);
  endtask

  // boot reachable from init only, file transfer only
  task automatic t_boot;
    m.set_state(4'h3); #1 chk(16'(state_err), 16'h0001);
    m.set_state(4'h1); #1 chk(16'(state_code), 16'h0001);
    m.set_state(4'h3); #1 chk(16'(state_code), 16'h0003);
    m.send_mbx(1'b0); #1 chk(16'(mbx_nak), 16'h0001);
    m.send_mbx(1'b1); #1 chk(16'(mbx_ack), 16'h0001);
    m.send_pd(8'h00); #1 chk(16'(pd_nak), 16'h0001);
  endtask

  // main sequence
  initial begin
    {reset, mbx_cfg_ok, pd_cfg_ok, clk_sync_ok, app_access, in_pins} = {5'b10000, 8'h00};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_init();
    t_config();
    t_run();
    t_boot();
    print_verdict();
  end

  // hang guard
  initial begin
    #60000;
    n_mismatch++;
    print_verdict();
  end
endmodule
